//--- frcc_pkg.sv
// package: register map, field layout and types of the capture/compare timer
package frcc_pkg;
  localparam int unsigned NUM_CH    = 4;
  localparam int unsigned CNT_W     = 16;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00; // run bit, per-channel capture select
  localparam logic [7:0] OFF_OPT    = 8'h04; // bit0 wrap flag, write zero clears
  localparam logic [7:0] OFF_COUNT  = 8'h08; // counter read-back
  localparam logic [7:0] OFF_EDGE   = 8'h0c; // 2 bits per channel edge select
  localparam logic [7:0] OFF_STAT   = 8'h10; // sticky events, write one clears
  localparam logic [7:0] OFF_MASK   = 8'h14; // interrupt enables
  localparam logic [7:0] OFF_CCR0   = 8'h20; // channel registers, 4 bytes apart
  // field positions
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_CAP_LSB  = 4;
  localparam int unsigned STAT_WRAP_BIT = 4;
  localparam int unsigned OPT_WRAP_BIT  = 0;
  // reset values and counter top
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_TOP  = 16'hffff;
  localparam logic [CNT_W-1:0] CCR_RST  = 16'h0000;
  localparam logic [4:0]       MASK_RST = 5'h00;
  localparam logic [7:0]       EDGE_RST = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one capture/compare channel's configuration
  typedef struct packed {
    logic       capture;  // 1 capture, 0 compare
    logic [1:0] edge_sel; // 0 none, 1 rising, 2 falling, 3 both
  } frcc_cfg_s;

  typedef struct packed {
    logic       run;
    logic       wrap;
    logic [4:0] stat;
    logic [4:0] mask;
  } frcc_ctl_s;
endpackage : frcc_pkg

//--- frcc_channel.sv
// one capture/compare channel: edge detect, capture latch, match compare
`timescale 1ns/100ps
module frcc_channel
  import frcc_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire frcc_cfg_s        cfg_in,
  input  wire logic             run_in,
  input  wire logic [W-1:0]     count_in,
  input  wire logic             pin_in,
  input  wire logic             wr_in,
  input  wire logic [W-1:0]     wdata_in,
  output logic [W-1:0]          ccr_out,
  output logic                  event_out,
  output logic                  tout_out
);
  typedef struct packed {
    logic [W-1:0] ccr;
    logic         pin;
    logic         evt;
    logic         tout;
    logic         run;
  } frcc_ch_s;

  frcc_ch_s st_q;
  frcc_ch_s st_d;
  logic     rise;
  logic     fall;
  logic     hit;

  // edge detect, capture and compare
  always_comb begin
    st_d = st_q;
    rise = pin_in & ~st_q.pin;
    fall = ~pin_in & st_q.pin;
    hit  = 1'b0;
    st_d.pin = pin_in;
    st_d.run = run_in;
    st_d.evt = 1'b0;
    if (cfg_in.capture) begin
      hit = run_in & ((cfg_in.edge_sel[0] & rise) | (cfg_in.edge_sel[1] & fall));
      if (hit) begin
        st_d.ccr = count_in;
      end else if (wr_in) begin
        st_d.ccr = wdata_in;
      end
    end else begin
      if (wr_in) begin
        st_d.ccr = wdata_in; // new value applies at once
      end
      // the first count value after start may match too, so a load of zero fires
      hit = run_in & (count_in == st_q.ccr);
      if (run_in & ~st_q.run) begin
        st_d.tout = ~st_q.tout;
      end
    end
    if (hit) begin
      st_d.evt = 1'b1;
      if (!cfg_in.capture) begin
        st_d.tout = ~st_d.tout; // start and match together cancel
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ccr_out   = st_q.ccr;
  assign event_out = st_q.evt;
  assign tout_out  = st_q.tout;

  capture_latch_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cfg_in.capture && run_in && cfg_in.edge_sel[0] && pin_in && !st_q.pin)
      |=> (st_q.ccr == $past(count_in) && st_q.evt))
    else $error("capture did not latch counter");
  match_toggle_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!cfg_in.capture && run_in && st_q.run && count_in == st_q.ccr && !wr_in)
      |=> (st_q.evt && st_q.tout != $past(st_q.tout)))
    else $error("compare match missed");
  cap_seen_c : cover property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_in.capture && st_q.evt);
  match_seen_c : cover property (@(posedge clk_in) disable iff (!rst_n_in)
    !cfg_in.capture && st_q.evt);
endmodule // frcc_channel

//--- frcc_top.sv
// free-running 16-bit timer with four capture/compare channels, axi4-lite slave
`timescale 1ns/100ps
module frcc_top
  import frcc_pkg::*;
#(
  parameter int unsigned N = NUM_CH
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // axi4-lite slave
  input  wire logic [7:0]       s_axi_awaddr_in,
  input  wire logic             s_axi_awvalid_in,
  output logic                  s_axi_awready_out,
  input  wire logic [31:0]      s_axi_wdata_in,
  input  wire logic [3:0]       s_axi_wstrb_in,
  input  wire logic             s_axi_wvalid_in,
  output logic                  s_axi_wready_out,
  output logic [1:0]            s_axi_bresp_out,
  output logic                  s_axi_bvalid_out,
  input  wire logic             s_axi_bready_in,
  input  wire logic [7:0]       s_axi_araddr_in,
  input  wire logic             s_axi_arvalid_in,
  output logic                  s_axi_arready_out,
  output logic [31:0]           s_axi_rdata_out,
  output logic [1:0]            s_axi_rresp_out,
  output logic                  s_axi_rvalid_out,
  input  wire logic             s_axi_rready_in,
  // pins
  input  wire logic [N-1:0]     channel_capture_input_in,
  output logic [N-1:0]          channel_timer_output_out,
  output logic                  irq_out
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    frcc_ctl_s        ctl;
    logic [N-1:0]     cap;
    logic [2*N-1:0]   edge_sel;
    logic             aw_got;
    logic [7:0]       awaddr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             irq;
    logic [N-1:0]     tout;
  } frcc_top_s;

  frcc_top_s st_q;
  frcc_top_s st_d;

  logic [CNT_W-1:0] ccr   [N];
  logic [N-1:0]     ch_evt;
  logic [N-1:0]     ch_tout;
  logic [N-1:0]     ch_wr;
  logic             do_wr;
  logic             wrap_now;

  assign do_wr    = st_q.aw_got & st_q.w_got & ~st_q.bvalid;
  assign wrap_now = st_q.ctl.run & (st_q.count == CNT_TOP);

  // one channel instance per capture/compare register
  for (genvar i = 0; i < N; i++) begin : g_ch
    frcc_cfg_s cfg;
    assign cfg.capture  = st_q.cap[i];
    assign cfg.edge_sel = st_q.edge_sel[2*i +: 2];
    assign ch_wr[i] = do_wr && st_q.wstrb[1:0] == 2'h3
                      && st_q.awaddr == OFF_CCR0 + 8'(4*i);
    frcc_channel #(.W(CNT_W)) u_ch (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .cfg_in    (cfg),
      .run_in    (st_q.ctl.run),
      .count_in  (st_q.count),
      .pin_in    (channel_capture_input_in[i]),
      .wr_in     (ch_wr[i]),
      .wdata_in  (st_q.wdata[CNT_W-1:0]),
      .ccr_out   (ccr[i]),
      .event_out (ch_evt[i]),
      .tout_out  (ch_tout[i])
    );

    // a compare-mode write lands in that channel at once
    ccr_load_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ch_wr[i] && !st_q.cap[i]) |=> (ccr[i] == $past(st_q.wdata[CNT_W-1:0])))
      else $error("channel register write lost");
    evt_keep_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ch_evt[i] |=> st_q.ctl.stat[i])
      else $error("channel event not recorded");
  end

  // counter, flags, bus handshake and register file
  always_comb begin
    st_d = st_q;
    st_d.tout = ch_tout;
    // counter runs while enabled, wraps FFFFH to 0000H
    if (!st_q.ctl.run) begin
      st_d.count = CNT_RST;
    end else begin
      st_d.count = st_q.count + 16'h0001;
    end
    // write channel accept
    if (s_axi_awvalid_in && !st_q.aw_got) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_q.w_got) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata_in;
      st_d.wstrb = s_axi_wstrb_in;
    end
    if (do_wr) begin
      st_d.bvalid = 1'b1;
      st_d.bresp  = RESP_OKAY;
      unique case (st_q.awaddr)
        OFF_CTRL: begin
          if (st_q.wstrb[0]) begin
            st_d.ctl.run = st_q.wdata[CTRL_RUN_BIT];
            st_d.cap     = st_q.wdata[CTRL_CAP_LSB +: N];
          end
        end
        OFF_OPT: begin
          if (st_q.wstrb[0] && !st_q.wdata[OPT_WRAP_BIT]) begin
            st_d.ctl.wrap = 1'b0;
          end
        end
        OFF_EDGE: begin
          if (st_q.wstrb[0]) begin
            st_d.edge_sel = st_q.wdata[2*N-1:0];
          end
        end
        OFF_STAT: begin
          if (st_q.wstrb[0]) begin
            st_d.ctl.stat = st_q.ctl.stat & ~st_q.wdata[4:0];
          end
        end
        OFF_MASK: begin
          if (st_q.wstrb[0]) begin
            st_d.ctl.mask = st_q.wdata[4:0];
          end
        end
        default: begin
          if (ch_wr == '0 && (st_q.awaddr < OFF_CCR0
              || st_q.awaddr > OFF_CCR0 + 8'(4*(N-1)) || st_q.awaddr[1:0] != 2'h0)) begin
            st_d.bresp = RESP_SLVERR;
          end
        end
      endcase
    end
    if (st_q.bvalid && s_axi_bready_in) begin
      st_d.bvalid = 1'b0;
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
    end
    // hardware sets win over software clears
    if (wrap_now) begin
      st_d.ctl.wrap = 1'b1;
      st_d.ctl.stat[STAT_WRAP_BIT] = 1'b1;
    end
    st_d.ctl.stat[N-1:0] = st_d.ctl.stat[N-1:0] | ch_evt;
    // read channel; reads have no side effect
    if (s_axi_arvalid_in && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = RESP_OKAY;
      st_d.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr_in)
        OFF_CTRL:  st_d.rdata[CTRL_CAP_LSB +: N+0] = st_q.cap;
        OFF_OPT:   st_d.rdata[OPT_WRAP_BIT] = st_q.ctl.wrap;
        OFF_COUNT: st_d.rdata[CNT_W-1:0] = st_q.count;
        OFF_EDGE:  st_d.rdata[2*N-1:0] = st_q.edge_sel;
        OFF_STAT:  st_d.rdata[4:0] = st_q.ctl.stat;
        OFF_MASK:  st_d.rdata[4:0] = st_q.ctl.mask;
        default: begin
          st_d.rresp = RESP_SLVERR;
          for (int k = 0; k < N; k++) begin
            if (s_axi_araddr_in == OFF_CCR0 + 8'(4*k)) begin
              st_d.rdata[CNT_W-1:0] = ccr[k];
              st_d.rresp = RESP_OKAY;
            end
          end
        end
      endcase
      if (s_axi_araddr_in == OFF_CTRL) begin
        st_d.rdata[CTRL_RUN_BIT] = st_q.ctl.run;
      end
    end else if (st_q.rvalid && s_axi_rready_in) begin
      st_d.rvalid = 1'b0;
    end
    st_d.irq = |(st_d.ctl.stat & st_d.ctl.mask);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready_out        = ~st_q.aw_got;
  assign s_axi_wready_out         = ~st_q.w_got;
  assign s_axi_bvalid_out         = st_q.bvalid;
  assign s_axi_bresp_out          = st_q.bresp;
  assign s_axi_arready_out        = ~st_q.rvalid;
  assign s_axi_rvalid_out         = st_q.rvalid;
  assign s_axi_rdata_out          = st_q.rdata;
  assign s_axi_rresp_out          = st_q.rresp;
  assign channel_timer_output_out = st_q.tout;
  assign irq_out                  = st_q.irq;

  // checks
  wrap_count_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_q.ctl.run && st_q.count == CNT_TOP && st_d.ctl.run)
      |=> (st_q.count == CNT_RST && st_q.ctl.wrap))
    else $error("counter did not wrap to zero");
  count_step_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_q.ctl.run && $past(st_q.ctl.run)) |-> st_q.count == $past(st_q.count) + 16'h0001)
    else $error("counter did not step by one");
  wrap_sticky_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_q.ctl.wrap && !(do_wr && st_q.awaddr == OFF_OPT)) |=> st_q.ctl.wrap)
    else $error("wrap flag dropped on its own");
  wrap_read_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_q.ctl.wrap && s_axi_arvalid_in && !do_wr) |=> st_q.ctl.wrap)
    else $error("read changed wrap flag");
  wrap_clear_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (do_wr && st_q.awaddr == OFF_OPT && st_q.wstrb[0] && !st_q.wdata[0] && !wrap_now)
      |=> !st_q.ctl.wrap)
    else $error("wrap flag not cleared by write");
  wrap_shared_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wrap_now |=> (st_q.ctl.stat[STAT_WRAP_BIT] && st_q.ctl.wrap))
    else $error("shared wrap flag not set");
  event_sticky_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ch_evt[0] |=> st_q.ctl.stat[0])
    else $error("channel event not recorded");
  cap_multi_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ch_evt == 4'hf) |=> (st_q.ctl.stat[3:0] == 4'hf))
    else $error("concurrent captures lost");
  irq_level_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (|(st_q.ctl.stat & st_q.ctl.mask)) |-> irq_out)
    else $error("interrupt not raised");

  // bus answers stand until taken, one update per write
  bvalid_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_axi_bvalid_out && !s_axi_bready_in) |=> (s_axi_bvalid_out && $stable(s_axi_bresp_out)))
    else $error("write response dropped early");
  rvalid_hold_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_axi_rvalid_out && !s_axi_rready_in) |=> (s_axi_rvalid_out && $stable(s_axi_rdata_out)))
    else $error("read data dropped early");
  wr_once_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    do_wr |=> !do_wr)
    else $error("one write applied twice");
  aw_block_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_q.aw_got && !(st_q.bvalid && s_axi_bready_in)) |=> !s_axi_awready_out)
    else $error("address taken before response");
  rd_misalign_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[1:0] != 2'h0)
      |=> (s_axi_rresp_out == RESP_SLVERR))
    else $error("misaligned read not refused");

  // counter and wrap event details
  count_stop_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !st_q.ctl.run |=> (st_q.count == CNT_RST))
    else $error("stopped counter moved");
  wrap_irq_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wrap_now && st_q.ctl.mask[STAT_WRAP_BIT] && !(do_wr && st_q.awaddr == OFF_MASK))
      |=> irq_out)
    else $error("wrap interrupt not raised");
  stat_clear_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (do_wr && st_q.awaddr == OFF_STAT && st_q.wstrb[0]
      && st_q.wdata[STAT_WRAP_BIT] && !wrap_now)
      |=> !st_q.ctl.stat[STAT_WRAP_BIT])
    else $error("wrap event not cleared by write");
  set_wins_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wrap_now && do_wr && st_q.awaddr == OFF_OPT) |=> st_q.ctl.wrap)
    else $error("clear beat a new wrap");

  wrap_seen_c : cover property (@(posedge clk_in) disable iff (!rst_n_in) wrap_now);
  all_cap_c : cover property (@(posedge clk_in) disable iff (!rst_n_in) ch_evt == 4'hf);
  irq_c : cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(irq_out));
endmodule // frcc_top

//--- tb_free_running_capture_compare.sv
// self-checking bench for the free-running capture/compare timer
`timescale 1ns/100ps
module tb_free_running_capture_compare
  import frcc_pkg::*;
();
  logic        clk_in = 1'b0;
  logic        rst_n_in;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data, rdat, c0;
  logic [3:0]  w_strb, cap_pins, pins_d, tout;
  logic        aw_v, aw_r, w_v, w_r, b_v, b_rdy, ar_v, ar_r, r_v, r_rdy, irq;
  logic [1:0]  b_resp, r_resp, last_resp;
  logic [15:0] ccr_m [4];
  int          t_up [4];
  int          t_dn [4];
  int          err_total, checks_done, seed, cyc_cnt, t_old, t_new, run_at, n_wrap, span;
  logic [3:0]  soft_wrap;

  frcc_top DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_r),
    .s_axi_wdata_in(w_data), .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_r), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v),
    .s_axi_bready_in(b_rdy), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_r), .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
    .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_rdy),
    .channel_capture_input_in(cap_pins), .channel_timer_output_out(tout), .irq_out(irq)
  );

  // 20 mhz clock
  always #25 clk_in = ~clk_in;

  // verdict and end of run
  task automatic test_done();
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // cycle count and hang guard
  always @(posedge clk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 90000) begin
      err_total++;
      test_done();
    end
  end

  // compare seen against expected
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    aw_addr <= a;
    w_data  <= d;
    w_strb  <= 4'hf;
    aw_v    <= 1'b1;
    w_v     <= 1'b1;
    b_rdy   <= 1'b1;
    do begin
      @(posedge clk_in);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v);
    b_rdy <= 1'b0;
    last_resp = b_resp;
  endtask

  // axi4-lite read
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    ar_addr <= a;
    ar_v    <= 1'b1;
    r_rdy   <= 1'b1;
    do begin
      @(posedge clk_in);
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v);
    r_rdy <= 1'b0;
    rdat = r_data;
    last_resp = r_resp;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(nm, rdat, exp);
  endtask

  // main sequence
  initial begin
    seed = 7;
    rst_n_in = 1'b0;
    {aw_addr, ar_addr, w_data, w_strb, aw_v, w_v, b_rdy, ar_v, r_rdy} = '0;
    cap_pins = 4'h0;
    pins_d = 4'h0;
    cyc_cnt = 0;
    n_wrap = 0;
    soft_wrap = 4'h0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // reset values of all mapped registers, then unmapped and misaligned places
    for (int i = 0; i < 10; i++) begin
      rchk("reset value", (i < 6) ? 8'(4 * i) : OFF_CCR0 + 8'(4 * (i - 6)), 32'h0);
      chk("reset resp", {30'h0, last_resp}, {30'h0, RESP_OKAY});
    end
    rchk("unmapped data", 8'h18, 32'h0);
    chk("unmapped resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    rd(8'h02);
    chk("misaligned resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wr(8'h18, 32'h1);
    chk("unmapped wr resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    // four compare channels on one counter
    for (int m = 0; m < 4; m++) begin
      ccr_m[m] = 16'h0040 + 16'(m * 16) + 16'($random(seed) & 7);
      wr(OFF_CCR0 + 8'(4 * m), {16'h0, ccr_m[m]});
    end
    wr(OFF_COUNT, 32'h1234);
    rchk("count stopped", OFF_COUNT, 32'h0);
    wr(OFF_CTRL, 32'h1);
    run_at = cyc_cnt; // model: counter is zero in the cycle that ends at this edge
    cyc(4);
    chk("start toggle", {28'h0, tout}, 32'hf);
    cyc(256);
    rchk("match events", OFF_STAT, 32'hf);
    chk("match toggle", {28'h0, tout}, 32'h0);
    chk("masked irq", {31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'h1f);
    cyc(2);
    chk("unmasked irq", {31'h0, irq}, 32'h1);
    wr(OFF_STAT, 32'hf);
    cyc(2);
    chk("cleared irq", {31'h0, irq}, 32'h0);
    // software reload of channel 0 for the next interval
    rd(OFF_COUNT);
    chk("count read", rdat, 32'(16'(cyc_cnt - 1 - run_at)));
    ccr_m[0] = rdat[15:0] + 16'h0020;
    wr(OFF_CCR0, {16'h0, ccr_m[0]});
    cyc(64);
    rchk("reload event", OFF_STAT, 32'h1);
    chk("reload toggle", {28'h0, tout}, 32'h1);
    wr(OFF_STAT, 32'h1f);
    // capture mode on all channels, one edge mode each, none on channel 3
    wr(OFF_EDGE, 32'h39);
    wr(OFF_CTRL, 32'hf1);
    for (int m = 0; m < 4; m++) begin
      t_up[m] = $random(seed) & 15;
      t_dn[m] = 16 + ($random(seed) & 15);
    end
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_in);
      for (int m = 0; m < 4; m++) begin
        if (i == t_up[m]) pins_d[m] = 1'b1;
        if (i == t_dn[m]) pins_d[m] = 1'b0;
      end
      cap_pins <= pins_d;
      if (i == t_up[0]) t_old = cyc_cnt;
    end
    cyc(4);
    rd(OFF_CCR0);
    c0 = rdat;
    chk("first capture", c0, 32'(16'(t_old + 1 - run_at)));
    rd(OFF_CCR0 + 8'h04);
    chk("fall capture", {16'h0, rdat[15:0] - c0[15:0]}, 32'(16'(t_dn[1] - t_up[0])));
    rd(OFF_CCR0 + 8'h08);
    chk("both capture", {16'h0, rdat[15:0] - c0[15:0]}, 32'(16'(t_dn[2] - t_up[0])));
    rchk("no edge", OFF_CCR0 + 8'h0c, {16'h0, ccr_m[3]});
    rchk("capture events", OFF_STAT, 32'h7);
    chk("capture irq", {31'h0, irq}, 32'h1);
    // one counter wrap between two captures
    wr(OFF_STAT, 32'h1f);
    rchk("flag before wrap", OFF_OPT, 32'h0);
    while (cyc_cnt < t_old + 65600) @(posedge clk_in); // span under two periods
    rchk("wrap flag", OFF_OPT, 32'h1);
    rchk("flag after read", OFF_OPT, 32'h1);
    wr(OFF_OPT, 32'h1);
    rchk("flag after one", OFF_OPT, 32'h1);
    rchk("wrap event", OFF_STAT, 32'h10);
    chk("wrap irq", {31'h0, irq}, 32'h1);
    // wrap service: count it, note it per channel, clear the shared flag
    if (rdat[STAT_WRAP_BIT]) begin
      n_wrap++;
      soft_wrap = 4'hf;
    end
    wr(OFF_OPT, 32'h0);
    rchk("flag cleared", OFF_OPT, 32'h0);
    @(posedge clk_in);
    cap_pins <= 4'h1;
    t_new = cyc_cnt;
    cyc(4);
    rd(OFF_CCR0);
    span = (soft_wrap[0] ? n_wrap : 0) * 32'h10000 + rdat - c0;
    chk("wrapped width", 32'(span), 32'(t_new - t_old));
    soft_wrap[0] = 1'b0;
    wr(OFF_STAT, 32'h1f);
    cyc(2);
    chk("final irq", {31'h0, irq}, 32'h0);
    test_done();
  end
endmodule // tb_free_running_capture_compare
